// [hdl/plc_map.svh]
// Register map, field positions and reset values of the programmable logic cell
//
// Function
// - In normal mode the four-input table gives any Boolean function of its inputs, chosen by the mask.
// - In arithmetic mode the table splits into a three-input sum table and a three-input carry table.
// - The arithmetic carry-out goes to a neighbour's carry-in and to the status word, never to the combinational or register outputs.
// - The four-input table holds 16 bits and outputs the bit addressed by its four inputs.
// - Mask bit index is the input combination with D as the most and A as the least significant bit.
// - In arithmetic mode mask bits 7..0 give the sum and bits 15..8 give the carry.
// - In synchronous mode the register honours sync load and sync clear, clear first; with neither active it takes its normal data path.
// - With cascade enabled the register takes its data from the cascade-in of the cell above.
// - The adaptive cell has top and bottom six-input tables, each with a 64-bit mask.
// - In extended mode both tables are five-input functions sharing five inputs, two more (input_f, ext_sel) select.
// - Adaptive arithmetic uses two pairs of four-input tables and two dedicated full adders.
// - Carry-in feeds the first adder, whose carry feeds the second, whose carry leaves the cell.
// - Adaptive arithmetic results may be output registered, unregistered, or both.
// - The four-input cell register may load from its own table or from an independent input.
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH

// Register byte offsets
`define PLC_CFG_OFS 12'h000
`define PLC_MASK4_OFS 12'h004
`define PLC_MASK_TOP_LO_OFS 12'h008
`define PLC_MASK_TOP_HI_OFS 12'h00c
`define PLC_MASK_BOT_LO_OFS 12'h010
`define PLC_MASK_BOT_HI_OFS 12'h014
`define PLC_STAT_OFS 12'h018

// Configuration field positions
`define PLC_CFG_ARITH 0
`define PLC_CFG_SYNC 1
`define PLC_CFG_LOAD_INV 2
`define PLC_CFG_CLR_INV 3
`define PLC_CFG_CASC 4
`define PLC_CFG_INDEP 5
`define PLC_CFG_AMODE_LO 6
`define PLC_CFG_AMODE_HI 7

// Reset values
`define PLC_CFG_RST 32'h0000_0000
`define PLC_MASK4_RST 16'h0000
`define PLC_MASK6_RST 64'h0000_0000_0000_0000

`endif

// [hdl/plc_pkg.sv]
// Types of the programmable logic cell
package plc_pkg;
	typedef enum logic [1:0] {
		PLC_AM_NORMAL,
		PLC_AM_EXTENDED,
		PLC_AM_ARITH
	} plc_amode_t;

	// Four-input cell pins
	typedef struct packed {
		logic [3:0] data;
		logic carry_in;
		logic cascade_in;
		logic indep_in;
		logic sync_load;
		logic sync_clr;
	} plc_cell_in_t;

	// Adaptive cell pins, data[5:0] are inputs A..input_f, ext_sel is the seventh
	typedef struct packed {
		logic [5:0] data;
		logic ext_sel;
		logic carry_in;
	} plc_acell_in_t;

	typedef struct packed {
		logic [1:0] sum_comb;
		logic [1:0] sum_reg;
		logic comb_output;
		logic carry_out;
	} plc_acell_out_t;

	// AHB-Lite slave side
	typedef struct packed {
		logic hsel;
		logic [11:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} plc_ahb_req_t;
endpackage

// [hdl/plc_cell.sv]
// Logic cell and adaptive cell with their configuration registers on AHB-Lite
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`include "plc_map.svh"

module plc_cell (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire plc_pkg::plc_ahb_req_t ahb_req,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire plc_pkg::plc_cell_in_t cell_in,
	output logic comb_output,
	output logic reg_output,
	output logic carry_out,
	input wire plc_pkg::plc_acell_in_t acell_in,
	output plc_pkg::plc_acell_out_t acell_out
);
	// Configuration state
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic [15:0] mask4_r;
	logic [15:0] mask4_nxt;
	logic [63:0] mask_top_r;
	logic [63:0] mask_top_nxt;
	logic [63:0] mask_bot_r;
	logic [63:0] mask_bot_nxt;

	// Bus state
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [11:0] wr_addr_r;
	logic [11:0] wr_addr_nxt;
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;

	// Register state of both cells
	logic cell_q_r;
	logic cell_q_nxt;
	logic [1:0] asum_q_r;
	logic [1:0] asum_q_nxt;

	// Four-input cell paths
	logic lut_out;
	logic lut_sum;
	logic lut_carry;
	logic [2:0] ab_c;
	logic load_eff;
	logic clr_eff;
	logic reg_d;

	// Adaptive cell paths
	plc_pkg::plc_amode_t amode;
	logic [31:0] top_fn;
	logic [31:0] bot_fn;
	logic [3:0] top_q;
	logic [3:0] bot_q;
	logic [1:0] adder_c;
	logic [1:0] adder_s;
	logic acell_comb;
	logic acell_carry;

	// Bus decode
	logic ahb_go;
	logic [31:0] stat_word;

	// Bus accepts every transfer with no wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign ahb_go = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

	// Status word of live cell outputs
	assign stat_word = {24'h00_0000, 2'b00, acell_carry, acell_comb, carry_out, comb_output,
		cell_q_r, asum_q_r[0]};

	// Mode decode of the adaptive cell
	always_comb
	begin
		if (cfg_r[`PLC_CFG_AMODE_HI])
			amode = plc_pkg::PLC_AM_ARITH;
		else if (cfg_r[`PLC_CFG_AMODE_LO])
			amode = plc_pkg::PLC_AM_EXTENDED;
		else
			amode = plc_pkg::PLC_AM_NORMAL;
	end

	// Four-input table, D is the top index bit
	always_comb
	begin
		ab_c = {cell_in.carry_in, cell_in.data[1], cell_in.data[0]};
		lut_out = mask4_r[cell_in.data];
		lut_sum = mask4_r[{1'b0, ab_c}];
		lut_carry = mask4_r[{1'b1, ab_c}];
		comb_output = cfg_r[`PLC_CFG_ARITH] ? lut_sum : lut_out;
		carry_out = cfg_r[`PLC_CFG_ARITH] & lut_carry;
	end

	// Cell register data path and sync controls
	always_comb
	begin
		load_eff = cfg_r[`PLC_CFG_SYNC] & (cell_in.sync_load ^ cfg_r[`PLC_CFG_LOAD_INV]);
		clr_eff = cfg_r[`PLC_CFG_SYNC] & (cell_in.sync_clr ^ cfg_r[`PLC_CFG_CLR_INV]);
		if (cfg_r[`PLC_CFG_CASC])
			reg_d = cell_in.cascade_in;
		else if (cfg_r[`PLC_CFG_INDEP])
			reg_d = cell_in.indep_in;
		else
			reg_d = comb_output;
		cell_q_nxt = cell_q_r;
		if (clr_eff)
			cell_q_nxt = 1'b0;
		else if (load_eff)
			cell_q_nxt = cell_in.data[2];
		else
			cell_q_nxt = reg_d;
	end
	assign reg_output = cell_q_r;

	// Four-input quarters of both six-input tables, one per value of inputs e and f
	genvar q;
	generate
		for (q = 0; q < 4; q++)
		begin : g_quarter
			assign top_q[q] = mask_top_r[{2'(q), acell_in.data[3:0]}];
			assign bot_q[q] = mask_bot_r[{2'(q), acell_in.data[3:0]}];
		end
	endgenerate

	// Five-input halves for extended mode, input_f picks the half
	always_comb
	begin
		top_fn = acell_in.data[5] ? mask_top_r[63:32] : mask_top_r[31:0];
		bot_fn = acell_in.data[5] ? mask_bot_r[63:32] : mask_bot_r[31:0];
	end

	// Two table pairs feed two chained full adders, idle outside arithmetic mode
	always_comb
	begin
		adder_s = 2'b00;
		adder_c = 2'b00;
		if (amode == plc_pkg::PLC_AM_ARITH)
		begin
			{adder_c[0], adder_s[0]} = 2'(top_q[0]) + 2'(top_q[1])
				+ 2'(acell_in.carry_in);
			{adder_c[1], adder_s[1]} = 2'(bot_q[0]) + 2'(bot_q[1])
				+ 2'(adder_c[0]);
		end
	end

	// Output select of the adaptive cell
	always_comb
	begin
		acell_comb = 1'b0;
		acell_carry = 1'b0;
		case (amode)
			plc_pkg::PLC_AM_NORMAL:
				acell_comb = mask_top_r[acell_in.data];
			plc_pkg::PLC_AM_EXTENDED:
				acell_comb = acell_in.ext_sel ? bot_fn[acell_in.data[4:0]]
					: top_fn[acell_in.data[4:0]];
			default:
			begin
				acell_comb = adder_s[0];
				acell_carry = adder_c[1];
			end
		endcase
	end

	// Registered and unregistered sums side by side
	always_comb
	begin
		acell_out.sum_comb = adder_s;
		acell_out.sum_reg = asum_q_r;
		acell_out.comb_output = acell_comb;
		acell_out.carry_out = acell_carry;
		asum_q_nxt = adder_s;
	end

	// Register file next values, write lands in the data phase
	always_comb
	begin
		cfg_nxt = cfg_r;
		mask4_nxt = mask4_r;
		mask_top_nxt = mask_top_r;
		mask_bot_nxt = mask_bot_r;
		hrdata_nxt = hrdata_r;
		wr_pend_nxt = ahb_go && ahb_req.hwrite;
		wr_addr_nxt = ahb_req.haddr;
		if (wr_pend_r)
		begin
			if (wr_addr_r == `PLC_CFG_OFS)
				cfg_nxt = ahb_req.hwdata[7:0];
			else if (wr_addr_r == `PLC_MASK4_OFS)
				mask4_nxt = ahb_req.hwdata[15:0];
			else if (wr_addr_r == `PLC_MASK_TOP_LO_OFS)
				mask_top_nxt[31:0] = ahb_req.hwdata;
			else if (wr_addr_r == `PLC_MASK_TOP_HI_OFS)
				mask_top_nxt[63:32] = ahb_req.hwdata;
			else if (wr_addr_r == `PLC_MASK_BOT_LO_OFS)
				mask_bot_nxt[31:0] = ahb_req.hwdata;
			else if (wr_addr_r == `PLC_MASK_BOT_HI_OFS)
				mask_bot_nxt[63:32] = ahb_req.hwdata;
		end
		if (ahb_go && !ahb_req.hwrite)
		begin
			if (ahb_req.haddr == `PLC_CFG_OFS)
				hrdata_nxt = {24'h00_0000, cfg_r};
			else if (ahb_req.haddr == `PLC_MASK4_OFS)
				hrdata_nxt = {16'h0000, mask4_r};
			else if (ahb_req.haddr == `PLC_MASK_TOP_LO_OFS)
				hrdata_nxt = mask_top_r[31:0];
			else if (ahb_req.haddr == `PLC_MASK_TOP_HI_OFS)
				hrdata_nxt = mask_top_r[63:32];
			else if (ahb_req.haddr == `PLC_MASK_BOT_LO_OFS)
				hrdata_nxt = mask_bot_r[31:0];
			else if (ahb_req.haddr == `PLC_MASK_BOT_HI_OFS)
				hrdata_nxt = mask_bot_r[63:32];
			else if (ahb_req.haddr == `PLC_STAT_OFS)
				hrdata_nxt = stat_word;
			else
				hrdata_nxt = 32'h0000_0000;
		end
	end

	// Configuration state, frozen while the clock enable is low
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cfg_r <= 8'(`PLC_CFG_RST);
			mask4_r <= `PLC_MASK4_RST;
			mask_top_r <= `PLC_MASK6_RST;
			mask_bot_r <= `PLC_MASK6_RST;
		end
		else if (clk_en)
		begin
			cfg_r <= cfg_nxt;
			mask4_r <= mask4_nxt;
			mask_top_r <= mask_top_nxt;
			mask_bot_r <= mask_bot_nxt;
		end
	end

	// Bus state, frozen with the rest so a stalled bus keeps its phase
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hrdata_r <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	// Four-input cell register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cell_q_r <= 1'b0;
		else if (clk_en)
			cell_q_r <= cell_q_nxt;
	end

	// Adaptive cell sum registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			asum_q_r <= 2'b00;
		else if (clk_en)
			asum_q_r <= asum_q_nxt;
	end
endmodule

// [dv/plc_cell_sva.sv]
// Port assertions of the logic cell
module plc_cell_sva (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire plc_pkg::plc_ahb_req_t ahb_req,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire plc_pkg::plc_cell_in_t cell_in,
	input wire logic comb_output,
	input wire logic reg_output,
	input wire logic carry_out
);
	logic wr_r;
	logic [11:0] wa_r;
	logic [7:0] cfg_r;
	logic [15:0] m_r;
	logic ld;
	logic cl;
	// Effective load and clear after inversion
	assign ld = cell_in.sync_load ^ cfg_r[2];
	assign cl = cell_in.sync_clr ^ cfg_r[3];
	// Shadow of config and mask writes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wr_r <= 1'b0;
			wa_r <= 12'h000;
			cfg_r <= 8'h00;
			m_r <= 16'h0000;
		end
		else if (clk_en)
		begin
			wr_r <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite;
			wa_r <= ahb_req.haddr;
			if (wr_r && wa_r == 12'h000)
				cfg_r <= ahb_req.hwdata[7:0];
			if (wr_r && wa_r == 12'h004)
				m_r <= ahb_req.hwdata[15:0];
		end
	end
	bus_ok_a: assert property (@(posedge clk_sys) hreadyout && !hresp) else $error("bus stalled");
	norm_lut_a: assert property (@(posedge clk_sys) disable iff (rst)
		!cfg_r[0] |-> comb_output == m_r[cell_in.data] && !carry_out) else $error("normal lut");
	arith_sum_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_r[0] |-> comb_output == m_r[{1'b0, cell_in.carry_in, cell_in.data[1:0]}])
		else $error("sum lut");
	arith_carry_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_r[0] |-> carry_out == m_r[{1'b1, cell_in.carry_in, cell_in.data[1:0]}])
		else $error("carry lut");
	clr_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && cfg_r[1] && cl |=> !reg_output) else $error("clear");
	sync_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && cfg_r[1] && !cl && ld |=> reg_output == $past(cell_in.data[2])) else $error("load");
	cascade_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && !cfg_r[1] && cfg_r[4] |=> reg_output == $past(cell_in.cascade_in))
		else $error("cascade");
	hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!clk_en |=> $stable(reg_output)) else $error("hold");
endmodule
bind plc_cell plc_cell_sva u_sva (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
	.ahb_req(ahb_req), .hreadyout(hreadyout), .hresp(hresp), .cell_in(cell_in),
	.comb_output(comb_output), .reg_output(reg_output), .carry_out(carry_out));

// [dv/plc_nbr.sv]
// Neighbour cells on the cascade and carry links
module plc_nbr (
	input wire logic clk_sys,
	input wire logic shift_in,
	input wire logic carry_in,
	output logic cascade_out,
	output logic carry_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// Register of the cell directly above
	always @(posedge clk_sys)
		cascade_out <= shift_in;
	// Carry lands only on this carry-in
	assign carry_seen = carry_in;
endmodule

// [dv/tb.sv]
// Self-checking bench of the logic cell
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst, clk_en, sh, casc, cseen, comb_o, reg_o, cry_o, rdy, hresp;
	logic [31:0] hrdata, got;
	int num_errors = 0, checks_done = 0, cyc = 0;
	plc_pkg::plc_ahb_req_t req;
	plc_pkg::plc_cell_in_t ci;
	plc_pkg::plc_acell_in_t ai;
	plc_pkg::plc_acell_out_t ao;
	wire plc_pkg::plc_cell_in_t cw = {ci.data, ci.carry_in, casc, ci.indep_in, ci.sync_load, ci.sync_clr};
	plc_cell DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .ahb_req(req), .hrdata(hrdata),
		.hreadyout(rdy), .hresp(hresp), .cell_in(cw), .comb_output(comb_o), .reg_output(reg_o),
		.carry_out(cry_o), .acell_in(ai), .acell_out(ao));
	plc_nbr u_nbr (.clk_sys(clk_sys), .shift_in(sh), .carry_in(cry_o), .cascade_out(casc),
		.carry_seen(cseen));
	// Clock and hang guard
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One single AHB transfer, read data left in got
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		req.hsel <= 1'b1;
		req.haddr <= a;
		req.htrans <= 2'h2;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		do @(posedge clk_sys); while (rdy !== 1'b1);
		req.htrans <= 2'h0;
		req.hwdata <= d;
		do @(posedge clk_sys); while (rdy !== 1'b1);
		got = hrdata;
	endtask
	// Let the register take one edge, then compare it
	task automatic ck(input logic e);
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(32'(reg_o), 32'(e));
		@(posedge clk_sys);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		req = '0;
		req.hready = 1'b1;
		ci = '0;
		ai = '0;
		sh = 1'b0;
		clk_en = 1'b1;
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(12'h000, 1'b0, 32'h0);
		chk(got, 32'h0);
		bus(12'h020, 1'b1, 32'h1234_5678);
		bus(12'h020, 1'b0, 32'h0);
		chk(got, 32'h0);
		bus(12'h004, 1'b1, 32'h0000_f666);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_sys);
			ci.data <= i[3:0];
			@(negedge clk_sys);
			chk(32'({comb_o, cry_o}), 32'({16'hf666 >> i} & 32'h1) << 1);
		end
		$display("normal done");
		bus(12'h000, 1'b1, 32'h1);
		bus(12'h004, 1'b1, 32'h0000_e896);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys);
			{ci.carry_in, ci.data[1:0]} <= i[2:0];
			@(negedge clk_sys);
			chk(32'({comb_o, cseen}), 32'({^i[2:0], i[2:0] inside {3, 5, 6, 7}}));
		end
		$display("arith done");
		bus(12'h000, 1'b1, 32'h2);
		ci.data[2] <= 1'b1;
		ci.sync_load <= 1'b1;
		ck(1'b1);
		ci.sync_clr <= 1'b1;
		ck(1'b0);
		ci.sync_clr <= 1'b0;
		ck(1'b1);
		bus(12'h000, 1'b1, 32'ha);
		ck(1'b0);
		bus(12'h000, 1'b1, 32'h2);
		clk_en <= 1'b0;
		ck(1'b0);
		clk_en <= 1'b1;
		$display("sync done");
		bus(12'h000, 1'b1, 32'h10);
		sh <= 1'b1;
		ck(1'b0);
		sh <= 1'b0;
		ck(1'b1);
		ck(1'b0);
		bus(12'h000, 1'b1, 32'h20);
		ci.indep_in <= 1'b1;
		ck(1'b1);
		$display("register done");
		bus(12'h00c, 1'b1, 32'hffff_0000);
		ai.data <= 6'h30;
		@(negedge clk_sys);
		chk(32'(ao.comb_output), 32'h1);
		@(posedge clk_sys);
		ai.data <= 6'h10;
		@(negedge clk_sys);
		chk(32'(ao.comb_output), 32'h0);
		bus(12'h008, 1'b1, 32'hffff_ffff);
		bus(12'h010, 1'b1, 32'h0000_ffff);
		bus(12'h008, 1'b0, 32'h0);
		chk(got, 32'hffff_ffff);
		bus(12'h004, 1'b0, 32'h0);
		chk(got, 32'h0000_e896);
		bus(12'h000, 1'b1, 32'h40);
		ai.ext_sel <= 1'b0;
		@(negedge clk_sys);
		chk(32'(ao.comb_output), 32'h1);
		@(posedge clk_sys);
		ai.ext_sel <= 1'b1;
		@(negedge clk_sys);
		chk(32'(ao.comb_output), 32'h0);
		bus(12'h000, 1'b1, 32'h80);
		ai.data <= 6'h00;
		ai.carry_in <= 1'b1;
		@(negedge clk_sys);
		chk(32'({ao.sum_comb, ao.comb_output, ao.carry_out}), 32'h7);
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(32'(ao.sum_reg), 32'h1);
		@(posedge clk_sys);
		ai.carry_in <= 1'b0;
		@(negedge clk_sys);
		chk(32'({ao.sum_comb, ao.comb_output, ao.carry_out}), 32'h1);
		bus(12'h018, 1'b0, 32'h0);
		chk(got, 32'h0000_0026);
		$display("adaptive done");
		final_report();
	end
endmodule
